/* File: mgs_pkg.sv */
// Package for the mic gain slot and headphone source register bank.
// Assumes a single 10 MHz clock domain and a plain strobe register port.
package mgs_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_RGAIN_PRI  = 8'h31;
    localparam logic [7:0] ADDR_RGAIN_S2   = 8'h11;
    localparam logic [7:0] ADDR_RGAIN_S3   = 8'h13;
    localparam logic [7:0] ADDR_ROUTE_CTRL = 8'h14;
    localparam logic [7:0] ADDR_SLOT_CTRL  = 8'h40;
    localparam logic [7:0] ADDR_SLOT_STAT  = 8'h41;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int         VALID_BIT       = 7;
    localparam int         GAIN_MSB        = 5;
    localparam int         SRC_LSB         = 6;
    localparam logic [7:0] RST_GAIN_PRI    = 8'h00;
    localparam logic [7:0] RST_GAIN_S2     = 8'h00;
    localparam logic [7:0] RST_GAIN_S3     = 8'h00;
    localparam logic [7:0] RST_ROUTE       = 8'h00;
    localparam int         HALF_DB_PER_LSB = 1;

    typedef enum logic [1:0] {
        SRC_MIC_PREAMP,
        SRC_FIRST_OPAMP,
        SRC_SECOND_OPAMP,
        SRC_NONE
    } mgs_src_type;

    typedef enum logic [1:0] {
        SLOT_PRIMARY,
        SLOT_SECOND,
        SLOT_THIRD
    } mgs_slot_type;
endpackage

/* File: mgs_route_dec.sv */
// Headphone source decoder: one-hot route enables from the select field.
// Assumes the select is a registered value from the register bank.
`timescale 1ns/1ns
module mgs_route_dec (
    input  wire logic [1:0] headphone_source_select_in,
    output logic            route_mic_preamp_out,
    output logic            route_first_opamp_out,
    output logic            route_second_opamp_out
);
    always_comb begin
        route_mic_preamp_out   = 1'b0;
        route_first_opamp_out  = 1'b0;
        route_second_opamp_out = 1'b0;
        unique case (mgs_pkg::mgs_src_type'(headphone_source_select_in))
            mgs_pkg::SRC_MIC_PREAMP:   route_mic_preamp_out   = 1'b1;
            mgs_pkg::SRC_FIRST_OPAMP:  route_first_opamp_out  = 1'b1;
            mgs_pkg::SRC_SECOND_OPAMP: route_second_opamp_out = 1'b1;
            mgs_pkg::SRC_NONE:         route_mic_preamp_out   = 1'b0;
        endcase
    end
endmodule

/* File: mgs_regs.sv */
// Register bank for right mic gain slots and headphone source routing.
// Assumes synchronous inputs, one clock, strobe bus with read data a cycle later.
//
// Behaviour
// - Third-slot valid high makes slot three the startup gain source once primary is written and second-slot valid is high.
// - Third-slot valid low (reset) keeps slot three gains unused at startup.
// - While slot three is active, primary and second slot gains are ignored.
// - Slot three serves only after primary and second slots are programmed.
// - Gain code maps linearly in half-dB steps, 0 gives 0 dB, 63 gives 31.5 dB.
// - Source select 00 preamp, 01 first opamp, 10 second opamp, 11 nothing.
// - Source select reads 00 after reset.
// - Second-slot valid high selects second slot over primary gains.
`timescale 1ns/1ns
module mgs_regs (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic       startup_in,
    output logic      [7:0] rdata_out,
    output logic      [5:0] active_gain_code_out,
    output logic      [6:0] active_gain_half_db_out,
    output logic      [1:0] active_slot_out,
    output logic            slot3_refused_out,
    output logic            route_mic_preamp_out,
    output logic            route_first_opamp_out,
    output logic            route_second_opamp_out
);
    logic [7:0] gain_pri_ff;
    logic [7:0] gain_s2_ff;
    logic [7:0] gain_s3_ff;
    logic [7:0] route_ff;
    logic       pri_done_ff;
    logic       refused_ff;
    logic [1:0] slot_ff;
    logic [5:0] code_ff;
    logic [7:0] rdata_ff;
    logic [1:0] nxt_slot;
    logic [5:0] nxt_code;
    logic       s3_valid;
    logic       s2_valid;
    logic       s3_allowed;

    assign s3_valid   = gain_s3_ff[mgs_pkg::VALID_BIT];
    assign s2_valid   = gain_s2_ff[mgs_pkg::VALID_BIT];
    // Slot three only counts once both earlier slots are in use
    assign s3_allowed = s3_valid && s2_valid && pri_done_ff;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gain_pri_ff <= mgs_pkg::RST_GAIN_PRI;
            gain_s2_ff  <= mgs_pkg::RST_GAIN_S2;
            gain_s3_ff  <= mgs_pkg::RST_GAIN_S3;
            route_ff    <= mgs_pkg::RST_ROUTE;
            pri_done_ff <= 1'b0;
        end else if (wr_in) begin
            unique case (addr_in)
                mgs_pkg::ADDR_RGAIN_PRI: begin
                    gain_pri_ff <= {2'h0, wdata_in[mgs_pkg::GAIN_MSB:0]};
                    pri_done_ff <= 1'b1;
                end
                mgs_pkg::ADDR_RGAIN_S2:   gain_s2_ff <= {wdata_in[7], 1'b0, wdata_in[5:0]};
                mgs_pkg::ADDR_RGAIN_S3:   gain_s3_ff <= {wdata_in[7], 1'b0, wdata_in[5:0]};
                mgs_pkg::ADDR_ROUTE_CTRL: route_ff   <= wdata_in;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Startup slot selection
    // ----------------------------------------------------------------
    always_comb begin
        if (s3_allowed) begin
            nxt_slot = 2'(mgs_pkg::SLOT_THIRD);
            nxt_code = gain_s3_ff[mgs_pkg::GAIN_MSB:0];
        end else if (s2_valid) begin
            nxt_slot = 2'(mgs_pkg::SLOT_SECOND);
            nxt_code = gain_s2_ff[mgs_pkg::GAIN_MSB:0];
        end else begin
            nxt_slot = 2'(mgs_pkg::SLOT_PRIMARY);
            nxt_code = gain_pri_ff[mgs_pkg::GAIN_MSB:0];
        end
    end

    // Gains latch only on startup so later writes do not disturb audio
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            slot_ff    <= 2'(mgs_pkg::SLOT_PRIMARY);
            code_ff    <= 6'h00;
            refused_ff <= 1'b0;
        end else if (startup_in) begin
            slot_ff    <= nxt_slot;
            code_ff    <= nxt_code;
            refused_ff <= s3_valid && !s3_allowed;
        end
    end

    assign active_slot_out         = slot_ff;
    assign active_gain_code_out    = code_ff;
    assign active_gain_half_db_out = {1'b0, code_ff} * 7'(mgs_pkg::HALF_DB_PER_LSB);
    assign slot3_refused_out       = refused_ff;

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_ff <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                mgs_pkg::ADDR_RGAIN_PRI:  rdata_ff <= gain_pri_ff;
                mgs_pkg::ADDR_RGAIN_S2:   rdata_ff <= gain_s2_ff;
                mgs_pkg::ADDR_RGAIN_S3:   rdata_ff <= gain_s3_ff;
                mgs_pkg::ADDR_ROUTE_CTRL: rdata_ff <= route_ff;
                mgs_pkg::ADDR_SLOT_STAT:  rdata_ff <= {5'h00, refused_ff, slot_ff};
                default:                  rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // Zero outside the read cycle, so stale data never lingers on the port
    assign rdata_out = rdata_ff;

    // Routing table kept in one place, outside the register logic
    mgs_route_dec u_route (
        .headphone_source_select_in (route_ff[mgs_pkg::SRC_LSB +: 2]),
        .route_mic_preamp_out       (route_mic_preamp_out),
        .route_first_opamp_out      (route_first_opamp_out),
        .route_second_opamp_out     (route_second_opamp_out)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_start_s3;
        startup_in && s3_allowed;
    endsequence

    sequence s_start_s2;
        startup_in && !s3_allowed && s2_valid;
    endsequence

    sequence s_start_pri;
        startup_in && !s3_allowed && !s2_valid;
    endsequence

    a_slot3_picked: assert property (@(posedge clk_in) disable iff (rst_in)
        s_start_s3 |=> active_slot_out == 2'(mgs_pkg::SLOT_THIRD)
        && active_gain_code_out == $past(gain_s3_ff[5:0]))
        else $error("third slot not chosen");

    a_slot3_unused: assert property (@(posedge clk_in) disable iff (rst_in)
        startup_in && !s3_valid |=> active_slot_out != 2'(mgs_pkg::SLOT_THIRD))
        else $error("invalid third slot used");

    a_others_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
        s_start_s3 ##1 (!startup_in)[*2] |-> active_gain_code_out == $past(gain_s3_ff[5:0], 2))
        else $error("other gains leaked in");

    a_slot3_gated: assert property (@(posedge clk_in) disable iff (rst_in)
        startup_in && s3_valid && !(s2_valid && pri_done_ff) |=> slot3_refused_out)
        else $error("third slot used too early");

    a_gain_scale: assert property (@(posedge clk_in) disable iff (rst_in)
        active_gain_half_db_out == {1'b0, active_gain_code_out})
        else $error("gain scale wrong");

    a_route_onehot: assert property (@(posedge clk_in) disable iff (rst_in)
        (route_ff[7:6] == 2'h3) == !(route_mic_preamp_out || route_first_opamp_out
        || route_second_opamp_out))
        else $error("route decode wrong");

    a_route_reset: assert property (@(posedge clk_in)
        $fell(rst_in) |-> route_mic_preamp_out && route_ff[7:6] == 2'h0)
        else $error("route not preamp after reset");

    a_slot2_picked: assert property (@(posedge clk_in) disable iff (rst_in)
        s_start_s2 |=> active_slot_out == 2'(mgs_pkg::SLOT_SECOND))
        else $error("second slot not chosen");

    a_priority: assert property (@(posedge clk_in) disable iff (rst_in)
        startup_in && !s3_allowed && !s2_valid |=> active_slot_out == 2'(mgs_pkg::SLOT_PRIMARY))
        else $error("primary fallback wrong");

    // Latched code must be the one held at the startup edge
    a_slot2_code: assert property (@(posedge clk_in) disable iff (rst_in)
        s_start_s2 |=> active_gain_code_out == $past(gain_s2_ff[mgs_pkg::GAIN_MSB:0]))
        else $error("second slot code not latched");

    a_primary_code: assert property (@(posedge clk_in) disable iff (rst_in)
        s_start_pri |=> active_gain_code_out == $past(gain_pri_ff[mgs_pkg::GAIN_MSB:0]))
        else $error("primary code not latched");

    a_slot3_steady: assert property (@(posedge clk_in) disable iff (rst_in)
        active_slot_out == 2'(mgs_pkg::SLOT_THIRD) && !startup_in
        |=> $stable(active_gain_code_out))
        else $error("gain moved while third slot active");

    a_refused_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        s_start_s3 |=> !slot3_refused_out)
        else $error("allowed third slot flagged refused");

    // Each field value drives exactly one source, none for the last code
    a_route_map: assert property (@(posedge clk_in) disable iff (rst_in)
        route_mic_preamp_out == (route_ff[7:6] == 2'h0)
        && route_first_opamp_out == (route_ff[7:6] == 2'h1)
        && route_second_opamp_out == (route_ff[7:6] == 2'h2))
        else $error("route select misdecoded");

    // Status read shows the slot latched at the last startup
    a_status_read: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_in && addr_in == mgs_pkg::ADDR_SLOT_STAT && !startup_in
        |=> rdata_out == {5'h00, slot3_refused_out, active_slot_out})
        else $error("status read wrong");
endmodule

/* File: mgs_regs_tb_top.sv */
// Self-checking bench for the mic gain slot and headphone source registers.
// Assumes mgs_pkg and mgs_regs are compiled first; assertions sit in the design.
`timescale 1ns/1ns
module mgs_regs_tb_top;
    // ----------------------------------------------------------------
    // Signals and reference state
    // ----------------------------------------------------------------
    logic       clk_in, rst_in, wr_in, rd_in, startup_in;
    logic [7:0] addr_in, wdata_in, rdata_out, m_pri, m_s2, m_s3, m_route, a;
    logic [5:0] gain_code;
    logic [6:0] half_db;
    logic [1:0] slot, m_slot;
    logic       refused, r_mic, r_op1, r_op2, m_pri_w, m_ref;
    logic [7:0] pick [6] = '{8'h31, 8'h11, 8'h13, 8'h14, 8'h40, 8'h41};
    integer     seed = 32'hc274e1fe;
    int         n_mismatch = 0;
    int         comparisons = 0;

    mgs_regs i_mgs_regs (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .startup_in(startup_in),
        .rdata_out(rdata_out), .active_gain_code_out(gain_code),
        .active_gain_half_db_out(half_db), .active_slot_out(slot),
        .slot3_refused_out(refused), .route_mic_preamp_out(r_mic),
        .route_first_opamp_out(r_op1), .route_second_opamp_out(r_op2));

    // ----------------------------------------------------------------
    // Compare, bus and reference tasks
    // ----------------------------------------------------------------
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] exp_rd(input logic [7:0] ad);
        case (ad)
            mgs_pkg::ADDR_RGAIN_PRI:  return m_pri & 8'h3f;
            mgs_pkg::ADDR_RGAIN_S2:   return m_s2 & 8'hbf;
            mgs_pkg::ADDR_RGAIN_S3:   return m_s3 & 8'hbf;
            mgs_pkg::ADDR_ROUTE_CTRL: return m_route;
            mgs_pkg::ADDR_SLOT_STAT:  return {5'h00, m_ref, m_slot};
            default:                  return 8'h00;
        endcase
    endfunction

    task automatic bus_wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk_in);
        wr_in    <= 1'b1;
        addr_in  <= ad;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        case (ad)
            mgs_pkg::ADDR_RGAIN_PRI:  m_pri_w = 1'b1;
            mgs_pkg::ADDR_RGAIN_S2:   m_s2 = d;
            mgs_pkg::ADDR_RGAIN_S3:   m_s3 = d;
            mgs_pkg::ADDR_ROUTE_CTRL: m_route = d;
            default:                  ;
        endcase
        if (ad == mgs_pkg::ADDR_RGAIN_PRI) m_pri = d;
    endtask

    task automatic bus_rd(input logic [7:0] ad);
        @(posedge clk_in);
        rd_in   <= 1'b1;
        addr_in <= ad;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk_val(rdata_out, exp_rd(ad));
    endtask

    // Priority third, second, primary; third needs both earlier slots
    task automatic do_startup();
        logic [1:0] es;
        logic [5:0] ec;
        es = (m_s3[7] && m_s2[7] && m_pri_w) ? 2'd2 : (m_s2[7] ? 2'd1 : 2'd0);
        ec = (es == 2'd2) ? m_s3[5:0] : ((es == 2'd1) ? m_s2[5:0] : m_pri[5:0]);
        m_slot = es;
        m_ref = m_s3[7] && !es[1];
        @(posedge clk_in);
        startup_in <= 1'b1;
        @(posedge clk_in);
        startup_in <= 1'b0;
        #1 chk_val(8'(slot), 8'(es));
        chk_flag(refused, m_s3[7] && !es[1]);
        chk_val(8'(gain_code), 8'(ec));
        chk_val(8'(half_db), 8'(ec));
        bus_rd(mgs_pkg::ADDR_SLOT_STAT);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    initial begin
        #2_000_000;
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        {rst_in, wr_in, rd_in, startup_in, addr_in, wdata_in} = {1'b1, 19'h0};
        {m_pri, m_s2, m_s3, m_route, m_pri_w, m_slot, m_ref} = 36'h0;
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        #1 chk_flag(r_mic, 1'b1);
        bus_rd(mgs_pkg::ADDR_ROUTE_CTRL);
        bus_wr(mgs_pkg::ADDR_RGAIN_S3, 8'h2a);
        do_startup();
        $display("test reset and idle slot done");
        bus_wr(mgs_pkg::ADDR_RGAIN_S3, 8'hbf);
        do_startup();
        bus_wr(mgs_pkg::ADDR_RGAIN_S2, 8'h8a);
        do_startup();
        bus_wr(mgs_pkg::ADDR_RGAIN_PRI, 8'hc5);
        do_startup();
        $display("test slot priority done");
        for (int s = 0; s < 4; s++) begin
            bus_wr(mgs_pkg::ADDR_ROUTE_CTRL, {2'(s), 6'h15});
            #1 chk_val({5'h00, r_mic, r_op1, r_op2}, (s == 3) ? 8'h00 : 8'h04 >> s);
            bus_rd(mgs_pkg::ADDR_ROUTE_CTRL);
        end
        $display("test headphone routes done");
        @(posedge clk_in);
        rst_in <= 1'b1;
        {m_pri, m_s2, m_s3, m_route, m_pri_w, m_slot, m_ref} = 36'h0;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        #1 chk_flag(r_mic, 1'b1);
        bus_rd(mgs_pkg::ADDR_ROUTE_CTRL);
        bus_rd(mgs_pkg::ADDR_RGAIN_S3);
        do_startup();
        $display("test mid-run reset done");
        for (int i = 0; i < 80; i++) begin
            a = pick[$unsigned($random(seed)) % 6];
            bus_wr(a, 8'($random(seed)));
            bus_rd(a);
            if ($unsigned($random(seed)) % 3 == 0) do_startup();
        end
        $display("test random traffic done");
        tally_and_finish();
    end
endmodule
